/* File: common/wrc_pkg.sv */
`default_nettype none
package wrc_pkg;
    // ********************************************************
    // Register map (byte addresses, one word each)
    // ********************************************************
    localparam logic [11:0] WDT_CONTROL_OFFS = 12'h000;
    localparam logic [11:0] RESET_KEY_OFFS   = 12'h004;
    localparam logic [11:0] CAUSE_FLAG_OFFS  = 12'h008;
    localparam logic [11:0] STATUS_OFFS      = 12'h00c;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int          KEY_FIELD_LSB    = 3;
    localparam int          RST_KEY_FLT_BIT  = 3;
    localparam int          WDT_KEY_FLT_BIT  = 0;
    localparam logic [4:0]  WDT_KEY_DISABLE  = 5'h15;
    localparam logic [4:0]  WDT_KEY_ENABLE   = 5'h0a;
    localparam logic [7:0]  WDT_CONTROL_RST  = 8'h53;
    localparam logic [7:0]  RESET_KEY_RST    = 8'h55;
    localparam logic [7:0]  RESET_KEY_ALT    = 8'haa;
    localparam logic [7:0]  PORT_RST         = 8'hff;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int          SYS_CLK_HZ       = 40000000;
    localparam int          SUB_CLK_HZ       = 32000;
    localparam int          SUB_TICK_CYCLES  = SYS_CLK_HZ / SUB_CLK_HZ;
    localparam int          SOFT_RST_CYCLES  = 64;
    localparam int          PIN_RST_CYCLES   = 1024;
    localparam int          POR_DELAY_CYCLES = 1024;

    // Reset kinds seen by the rest of the device
    typedef enum logic [2:0] {
        WRC_RST_NONE    = 3'b000,
        WRC_RST_POWERON = 3'b001,
        WRC_RST_PIN     = 3'b010,
        WRC_RST_WDT_RUN = 3'b011,
        WRC_RST_WDT_PD  = 3'b100,
        WRC_RST_SOFT    = 3'b101
    } wrc_rst_kind_t;

    // Reset request bundle
    typedef struct packed {
        logic          core_hold;
        logic          pc_sp_clear;
        logic          port_init;
        wrc_rst_kind_t kind;
    } wrc_reset_t;
endpackage
`default_nettype wire

/* File: dv/wrc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module wrc_chk #(
    parameter int PIN_DLY = 8
) (
    input wire logic                i_sys_clk,
    input wire logic                i_reset,
    input wire logic                i_ext_reset_n_pin,
    input wire wrc_pkg::wrc_reset_t o_reset_req,
    input wire logic                o_timeout_flag,
    input wire logic                o_powerdown_flag,
    input wire logic [7:0]          o_port_data_init,
    input wire logic [7:0]          o_port_dir_init
);
    // ********
    // Reset request checks
    // ********
    wire wrc_pkg::wrc_rst_kind_t kind = o_reset_req.kind;
    wire                         hold = o_reset_req.core_hold;
    logic [15:0]                 hold_r;
    // Pin-low time is excluded, so the count is the delay after release
    always_ff @(posedge i_sys_clk)
        hold_r <= (i_reset || !hold || !i_ext_reset_n_pin) ? 16'h0 : hold_r + 16'h1;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    a_por_state: assert property ($fell(i_reset) |-> hold && kind == wrc_pkg::WRC_RST_POWERON
        && !o_timeout_flag && !o_powerdown_flag) else $error("power-on state wrong");
    a_ports_high: assert property (o_port_data_init == 8'hff && o_port_dir_init == 8'hff)
        else $error("port init not all ones");
    a_hold_pc: assert property (hold |-> o_reset_req.pc_sp_clear)
        else $error("hold without pc clear");
    a_pin_entry: assert property ((!i_ext_reset_n_pin) [*6] |-> hold && kind == wrc_pkg::WRC_RST_PIN)
        else $error("pin low gave no pin reset");
    // Window of a few cycles absorbs the pin synchroniser
    a_hold_len: assert property ($fell(hold) && $past(kind) inside {wrc_pkg::WRC_RST_PIN,
        wrc_pkg::WRC_RST_SOFT, wrc_pkg::WRC_RST_WDT_RUN} |-> $past(hold_r) >= PIN_DLY - 2
        && $past(hold_r) <= PIN_DLY + 4) else $error("reset hold length wrong");
    a_pin_keep: assert property (hold && kind == wrc_pkg::WRC_RST_PIN |-> $stable(o_timeout_flag)
        && $stable(o_powerdown_flag)) else $error("pin reset changed flags");
    a_sleep_warm: assert property (hold && kind == wrc_pkg::WRC_RST_WDT_PD |-> !o_reset_req.port_init
        && o_powerdown_flag && o_timeout_flag) else $error("sleep timeout state wrong");
    a_run_flag: assert property (hold && kind == wrc_pkg::WRC_RST_WDT_RUN |-> o_timeout_flag
        && o_reset_req.port_init) else $error("run timeout state wrong");
    a_to_cause: assert property ($rose(o_timeout_flag) |-> ##[0:2] hold && kind inside
        {wrc_pkg::WRC_RST_WDT_RUN, wrc_pkg::WRC_RST_WDT_PD}) else $error("timeout flag without timeout");
    c_soft: cover property (hold && kind == wrc_pkg::WRC_RST_SOFT);
    c_run: cover property (hold && kind == wrc_pkg::WRC_RST_WDT_RUN);
    c_sleep: cover property (hold && kind == wrc_pkg::WRC_RST_WDT_PD);
    c_pin: cover property (hold && kind == wrc_pkg::WRC_RST_PIN);
endmodule // wrc_chk
bind wrc_watchdog_reset wrc_chk #(.PIN_DLY(PIN_DLY)) u_chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ext_reset_n_pin(i_ext_reset_n_pin),
    .o_reset_req(o_reset_req), .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag),
    .o_port_data_init(o_port_data_init), .o_port_dir_init(o_port_dir_init));
`default_nettype wire

/* File: dv/wrc_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module wrc_cpu_model #(
    parameter int KICK_GAP = 300
) (
    input  wire logic i_sys_clk,
    input  wire logic i_kick_en,
    input  wire logic i_sleep_req,
    output logic      o_wdt_clear_instr,
    output logic      o_halt_instr
);
    // ********
    // Core instruction stream
    // ********
    logic [15:0] gap_r;
    logic        sleep_r;
    initial begin
        gap_r = 16'h0;
        sleep_r = 1'b0;
        o_wdt_clear_instr = 1'b0;
        o_halt_instr = 1'b0;
    end
    // First clear comes at once, so a count left from before never wins
    always @(posedge i_sys_clk) begin
        gap_r <= (!i_kick_en || gap_r == 16'(KICK_GAP - 1)) ? 16'h0 : gap_r + 16'h1;
        o_wdt_clear_instr <= i_kick_en && gap_r == 16'h0;
        sleep_r <= i_sleep_req;
        o_halt_instr <= i_sleep_req && !sleep_r; // halt is a single pulse
    end
endmodule // wrc_cpu_model
`default_nettype wire

/* File: dv/wrc_watchdog_reset_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module wrc_watchdog_reset_bench;
    // ********
    // Stimulus and checking
    // ********
    localparam int DLY = 8;
    logic        clk, rst, pin_n, psel, pen, pwr, kick, sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] expq[$];
    int          err_count, total_checks, cyc;
    wire         pready, clr_i, halt_i, to_f, pd_f;
    wire  [31:0] prdata;
    wire  [7:0]  pdat, pdir;
    wire wrc_pkg::wrc_reset_t req;
    wrc_watchdog_reset #(.SOFT_DLY(DLY), .PIN_DLY(DLY), .POR_DLY(DLY), .SUB_DIV(4)) uut (
        .i_sys_clk(clk), .i_reset(rst), .i_ext_reset_n_pin(pin_n), .i_wdt_clear_instr(clr_i),
        .i_halt_instr(halt_i), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(), .o_prdata(prdata), .o_reset_req(req),
        .o_timeout_flag(to_f), .o_powerdown_flag(pd_f), .o_port_data_init(pdat), .o_port_dir_init(pdir));
    wrc_cpu_model #(.KICK_GAP(300)) u_cpu (.i_sys_clk(clk), .i_kick_en(kick), .i_sleep_req(sleep),
        .o_wdt_clear_instr(clr_i), .o_halt_instr(halt_i));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A read notes its expected word; the monitor below compares it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expq.push_back(d);
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Sample after the edge lands, so no race with the design's flops
    task automatic wait_hold(input logic want, input int lim);
        int n;
        n = 0;
        while (req.core_hold !== want && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // Read monitor and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
        if (psel && pen && !pwr && pready === 1'b1)
            check(prdata, expq.pop_front());
    end
    initial begin
        logic [7:0] seed, bad;
        rst = 1'b1;
        pin_n = 1'b1;
        {psel, pen, pwr, kick, sleep} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        seed = 8'h62;
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_hold(1'b0, 100);
        check({pdat, pdir}, 16'hffff);
        apb(1'b0, wrc_pkg::WDT_CONTROL_OFFS, 32'h53);
        apb(1'b0, wrc_pkg::CAUSE_FLAG_OFFS, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        apb(1'b1, wrc_pkg::RESET_KEY_OFFS, 32'haa);
        apb(1'b0, wrc_pkg::RESET_KEY_OFFS, 32'haa);
        repeat (3 * DLY) @(posedge clk);
        check(req.core_hold, 1'b0);
        // Random corrupt keys: reset key first, then the watchdog key field
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            bad = i ? {seed[4:0], 3'b011} : seed;
            if (i == 0 && (seed == 8'h55 || seed == 8'haa))
                bad = seed ^ 8'h01;
            if (i == 1 && (seed[4:0] == 5'h0a || seed[4:0] == 5'h15))
                bad = bad ^ 8'h08;
            apb(1'b1, i ? wrc_pkg::WDT_CONTROL_OFFS : wrc_pkg::RESET_KEY_OFFS, {24'h0, bad});
            wait_hold(1'b1, 3 * DLY);
            check(32'(req.kind), 32'(wrc_pkg::WRC_RST_SOFT));
            wait_hold(1'b0, 4 * DLY);
            apb(1'b0, wrc_pkg::CAUSE_FLAG_OFFS, i ? 32'h1 : 32'h8);
            apb(1'b0, i ? wrc_pkg::WDT_CONTROL_OFFS : wrc_pkg::RESET_KEY_OFFS, i ? 32'h53 : 32'h55);
            apb(1'b1, wrc_pkg::CAUSE_FLAG_OFFS, 32'h0);
            apb(1'b0, wrc_pkg::CAUSE_FLAG_OFFS, 32'h0);
        end
        apb(1'b1, wrc_pkg::WDT_CONTROL_OFFS, 32'ha8);
        repeat (1400) @(posedge clk);
        check(req.core_hold, 1'b0);
        kick <= 1'b1;
        apb(1'b1, wrc_pkg::WDT_CONTROL_OFFS, 32'h50);
        repeat (2600) @(posedge clk);
        check(req.core_hold, 1'b0);
        kick <= 1'b0;
        wait_hold(1'b1, 1300);
        check(32'(req.kind), 32'(wrc_pkg::WRC_RST_WDT_RUN));
        check(to_f, 1'b1);
        wait_hold(1'b0, 4 * DLY);
        pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(32'(req.kind), 32'(wrc_pkg::WRC_RST_PIN));
        check(to_f, 1'b1);
        pin_n <= 1'b1;
        wait_hold(1'b0, 4 * DLY);
        apb(1'b1, wrc_pkg::WDT_CONTROL_OFFS, 32'h50);
        apb(1'b1, wrc_pkg::RESET_KEY_OFFS, 32'haa);
        sleep <= 1'b1;
        wait_hold(1'b1, 1300);
        check(32'(req.kind), 32'(wrc_pkg::WRC_RST_WDT_PD));
        check({to_f, pd_f}, 2'b11);
        sleep <= 1'b0;
        wait_hold(1'b0, 200);
        apb(1'b0, wrc_pkg::WDT_CONTROL_OFFS, 32'h50);
        apb(1'b0, wrc_pkg::RESET_KEY_OFFS, 32'haa);
        conclude();
    end
endmodule // wrc_watchdog_reset_bench
`default_nettype wire

/* File: hw/wrc_watchdog_reset.sv */
`timescale 1ns/100ps
`default_nettype none
module wrc_watchdog_reset #(
    parameter int SOFT_DLY = wrc_pkg::SOFT_RST_CYCLES,
    parameter int PIN_DLY  = wrc_pkg::PIN_RST_CYCLES,
    parameter int POR_DLY  = wrc_pkg::POR_DELAY_CYCLES,
    parameter int SUB_DIV  = wrc_pkg::SUB_TICK_CYCLES
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_reset,
    input  wire logic          i_ext_reset_n_pin,
    input  wire logic          i_wdt_clear_instr,
    input  wire logic          i_halt_instr,
    input  wire logic          i_psel,
    input  wire logic          i_penable,
    input  wire logic          i_pwrite,
    input  wire logic [11:0]   i_paddr,
    input  wire logic [31:0]   i_pwdata,
    output logic               o_pready,
    output logic               o_pslverr,
    output logic [31:0]        o_prdata,
    output wrc_pkg::wrc_reset_t o_reset_req,
    output logic               o_timeout_flag,
    output logic               o_powerdown_flag,
    output logic [7:0]         o_port_data_init,
    output logic [7:0]         o_port_dir_init
);
    // ********************************************************
    // Pin synchroniser
    // ********************************************************
    // The reset pin comes from a board network with a slow edge.
    // Both flops reset high so that reset release never looks like a press.
    // Only the second flop feeds logic; the first may go metastable.
    // A press shorter than one clock may be missed entirely.
    // That is fine, since an RC network holds the pin far longer.
    // The cost is two cycles of latency on entry and on exit.
    // The hold length check allows for that latency.
    logic pin_meta_r;
    logic pin_sync_r;
    // Two flops; the raw pin is asynchronous
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= i_ext_reset_n_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ********************************************************
    // Sequencer state
    // ********************************************************
    typedef enum logic [1:0] {
        WRC_ST_RUN   = 2'b00,
        WRC_ST_HOLD  = 2'b01,
        WRC_ST_DELAY = 2'b10
    } wrc_state_t;

    // RUN: core executes and the watchdog may count.
    // HOLD: pin held low, the core stays frozen.
    // DELAY: start-up wait after a reset cause has gone.
    // Every reset cause passes through DELAY before RUN.
    // Power-on enters DELAY straight from the bus reset.
    // The kind register records why the core is held.
    // Soft key checks and counters are idle outside RUN.
    // An unused code returns to HOLD, the safest place.
    wrc_state_t              state_r;
    wrc_state_t              state_nxt;
    wrc_pkg::wrc_rst_kind_t  kind_r;
    logic [19:0]             dly_cnt_r;
    logic [7:0]              wdt_ctrl_r;
    logic [7:0]              rst_key_r;
    logic                    wrf_r;
    logic                    reset_key_fault_flag_r;
    logic                    to_r;
    logic                    pdf_r;
    logic                    soft_wdt_r;
    logic                    soft_rst_r;
    logic [15:0]             soft_cnt_r;
    logic [15:0]             sub_pre_r;
    logic [17:0]             wdt_cnt_r;

    // ********************************************************
    // APB decode
    // ********************************************************
    // Zero wait states: every access ends in its first access cycle.
    // Writes land at the access edge; reads are captured at setup.
    // Unmapped offsets raise the error response and read as zero.
    // The status word is read only; writes to it are dropped.
    // Only the low byte of each word is implemented.
    // Upper write data bits are ignored without an error.
    // Byte strobes are not supported; every write is a full word.
    // Protection attributes are ignored for the same reason.
    wire        apb_wr    = i_psel & i_penable & i_pwrite;
    wire        hit_ctrl  = (i_paddr == wrc_pkg::WDT_CONTROL_OFFS);
    wire        hit_key   = (i_paddr == wrc_pkg::RESET_KEY_OFFS);
    wire        hit_flag  = (i_paddr == wrc_pkg::CAUSE_FLAG_OFFS);
    wire        hit_stat  = (i_paddr == wrc_pkg::STATUS_OFFS);
    wire        hit_any   = hit_ctrl | hit_key | hit_flag | hit_stat;
    wire        wr_ctrl   = apb_wr & hit_ctrl;
    wire        wr_key    = apb_wr & hit_key;
    wire        wr_flag   = apb_wr & hit_flag;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit_any;

    // ********************************************************
    // Key checks and watchdog divider
    // ********************************************************
    // Both key registers are checked every cycle, not only on writes.
    // A flip by noise therefore triggers the same soft reset.
    // Patterns are chosen so that single bit faults never match.
    // The timeout select gives ratios of two to the eighth and up.
    // The counter width covers the longest ratio of the select.
    // A tick is one period of the divided system clock.
    // Overflow fires on the tick that would wrap the chosen width.
    wire [4:0]  key_field = wdt_ctrl_r[7:wrc_pkg::KEY_FIELD_LSB];
    wire        wdt_on    = (key_field == wrc_pkg::WDT_KEY_ENABLE);
    wire        wdt_off   = (key_field == wrc_pkg::WDT_KEY_DISABLE);
    wire        wkey_bad  = ~wdt_on & ~wdt_off;
    wire        rkey_bad  = (rst_key_r != wrc_pkg::RESET_KEY_RST) &
                            (rst_key_r != wrc_pkg::RESET_KEY_ALT);
    wire        sub_tick  = (sub_pre_r == 16'(SUB_DIV - 1));
    wire [2:0]  tsel      = wdt_ctrl_r[2:0];
    // Ratio 2^8..2^18; code 110 unlisted, taken as 2^17
    wire [4:0]  ratio_log = (tsel < 3'h4) ? (5'd8 + {1'b0, tsel, 1'b0}) : (5'd11 + {2'b00, tsel});
    // Bits above the ratio are forced high; all ones means the last tick
    wire [17:0] ovf_mask  = 18'(~((19'h1 << ratio_log) - 19'h1));
    wire        wdt_ovf   = wdt_on & sub_tick & ((wdt_cnt_r | ovf_mask) == 18'h3ffff);
    wire        running   = (state_r == WRC_ST_RUN);
    wire        pin_low   = ~pin_sync_r;
    wire        soft_fire = (soft_wdt_r | soft_rst_r) & (soft_cnt_r == 16'(SOFT_DLY - 1));

    // Counter clear sources; bad key write included
    wire        wdt_clr   = i_wdt_clear_instr | i_halt_instr | pin_low |
                            (wr_ctrl & (i_pwdata[7:3] != wrc_pkg::WDT_KEY_ENABLE) &
                             (i_pwdata[7:3] != wrc_pkg::WDT_KEY_DISABLE));

    // ********************************************************
    // Sub clock prescaler and watchdog counter
    // ********************************************************
    // The prescaler stands in for the slow internal oscillator.
    // Deriving it from the system clock avoids a second domain.
    // The limitation: the timeout scales with the system clock.
    // It is held at zero while the core is in reset.
    // So each run phase starts with a full sub clock period.
    // The divider parameter sets the nominal sub clock rate.
    // Simulation uses a small divider to keep runs short.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !running || sub_tick) begin
            sub_pre_r <= 16'h0000;
        end else begin
            sub_pre_r <= sub_pre_r + 16'h0001;
        end
    end

    // Stops while disabled; resets on any clear source
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || wdt_clr || !running || wdt_ovf) begin
            wdt_cnt_r <= 18'h00000;
        end else if (wdt_on && sub_tick) begin
            wdt_cnt_r <= wdt_cnt_r + 18'h00001;
        end
    end

    // ********************************************************
    // Soft reset delay after a bad key
    // ********************************************************
    // A bad key arms its flag one cycle after it is stored.
    // The arm flags stick, so repairing the key does not cancel.
    // The counter then runs the soft delay to the reset.
    // Both causes share one counter; either may fire it.
    // Each arm flag selects which fault flag will be set.
    // Entering reset clears the arm flags and the counter.
    // Reloading the keys on entry keeps them from re-arming.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !running) begin
            soft_wdt_r <= 1'b0;
            soft_rst_r <= 1'b0;
            soft_cnt_r <= 16'h0000;
        end else begin
            soft_wdt_r <= soft_wdt_r | wkey_bad;
            soft_rst_r <= soft_rst_r | rkey_bad;
            if (soft_wdt_r || soft_rst_r) begin
                soft_cnt_r <= soft_cnt_r + 16'h0001;
            end
        end
    end

    // ********************************************************
    // Reset sequencer
    // ********************************************************
    // Entry happens only from RUN; timeout and soft causes during a reset are dropped.
    // A pin press during DELAY returns to HOLD and restarts the wait.
    // HOLD reloads the delay counter every cycle while the pin is low.
    // So the start-up wait is timed from the pin release.
    // Other causes load the counter on the entry edge.
    // The core is released on the edge after the count ends.
    // The power-on wait uses its own delay parameter.
    // Pin low wins over everything else; timeout beats soft fire
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WRC_ST_RUN: begin
                if (pin_low || wdt_ovf || soft_fire) begin
                    state_nxt = pin_low ? WRC_ST_HOLD : WRC_ST_DELAY;
                end
            end
            WRC_ST_HOLD: begin
                if (!pin_low) begin
                    state_nxt = WRC_ST_DELAY;
                end
            end
            WRC_ST_DELAY: begin
                if (pin_low) begin
                    state_nxt = WRC_ST_HOLD;
                end else if (dly_cnt_r == 20'h00000) begin
                    state_nxt = WRC_ST_RUN;
                end
            end
            default: begin
                state_nxt = WRC_ST_HOLD;
            end
        endcase
    end

    wire enter_rst = running & (pin_low | wdt_ovf | soft_fire);
    wire warm_pd   = running & ~pin_low & wdt_ovf & pdf_r;
    // Register reload pulse for cold kinds (not sleep timeout)
    wire reload    = enter_rst & ~warm_pd;
    // Cause of a new reset; published on the same edge as the hold
    wrc_pkg::wrc_rst_kind_t entry_kind;
    assign entry_kind = pin_low ? wrc_pkg::WRC_RST_PIN :
                        wdt_ovf ? (pdf_r ? wrc_pkg::WRC_RST_WDT_PD : wrc_pkg::WRC_RST_WDT_RUN) :
                        wrc_pkg::WRC_RST_SOFT;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r   <= WRC_ST_DELAY;
            kind_r    <= wrc_pkg::WRC_RST_POWERON;
            dly_cnt_r <= 20'(POR_DLY);
        end else begin
            state_r <= state_nxt;
            if (enter_rst) begin
                kind_r <= entry_kind;
                dly_cnt_r <= 20'(PIN_DLY);
            end else if (state_r == WRC_ST_HOLD) begin
                dly_cnt_r <= 20'(PIN_DLY);
            end else if (state_r == WRC_ST_DELAY && dly_cnt_r != 20'h00000) begin
                dly_cnt_r <= dly_cnt_r - 20'h00001;
            end
        end
    end

    // ********************************************************
    // Software registers
    // ********************************************************
    // Power-up and cold resets reload both key registers
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || reload) begin
            wdt_ctrl_r <= wrc_pkg::WDT_CONTROL_RST;
            rst_key_r  <= wrc_pkg::RESET_KEY_RST;
        end else begin
            if (wr_ctrl) begin
                wdt_ctrl_r <= i_pwdata[7:0];
            end
            if (wr_key) begin
                rst_key_r <= i_pwdata[7:0];
            end
        end
    end

    // Set wins over a clear in the same cycle; only writes of zero clear
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wrf_r  <= 1'b0;
            reset_key_fault_flag_r <= 1'b0;
        end else begin
            wrf_r  <= (soft_fire & soft_wdt_r & running) |
                      (wrf_r & ~(wr_flag & ~i_pwdata[wrc_pkg::WDT_KEY_FLT_BIT]));
            reset_key_fault_flag_r <= (soft_fire & soft_rst_r & running) |
                      (reset_key_fault_flag_r & ~(wr_flag & ~i_pwdata[wrc_pkg::RST_KEY_FLT_BIT]));
        end
    end

    // Timeout and powerdown flags
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            to_r  <= 1'b0;
            pdf_r <= 1'b0;
        end else if (running && wdt_ovf && !pin_low) begin
            to_r  <= 1'b1;
        end else if (running && (i_halt_instr || i_wdt_clear_instr)) begin
            to_r  <= 1'b0;
            pdf_r <= i_halt_instr;
        end
        // Pin and timeout resets leave the powerdown flag untouched.
        // Only power-up and the clear instruction bring it low.
        // Software reads both flags to tell the wake cause apart.
        // Clearing it on wake would hide a sleep timeout.
        // The halt pulse also clears the timeout flag.
    end

    // ********************************************************
    // Read data and outputs
    // ********************************************************
    // Read data is registered at setup, so it stands for the access.
    // The mux picks one byte by offset; others read as zero.
    // Unimplemented flag bits are tied low, never stored.
    // Status is read only and shows the two wake flags.
    // Reads have no side effects; flags clear by writing zero.
    // This keeps a debugger read from losing a fault record.
    wire [7:0] flag_rd = {4'h0, reset_key_fault_flag_r, 2'b00, wrf_r};
    wire [7:0] rd_byte = hit_ctrl ? wdt_ctrl_r :
                         hit_key  ? rst_key_r  :
                         hit_flag ? flag_rd    :
                         hit_stat ? {6'h00, to_r, pdf_r} : 8'h00;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= {24'h000000, rd_byte};
        end
    end

    // Hold and kind change together, so a sampler sees a coherent pair.
    // The kind reads none whenever the core is running.
    // While the core is held, port init is low only for the warm sleep timeout.
    // Port reset values are constants; the port block applies them.
    // A register stage keeps glitches off the core reset net.
    // Reset request: sleep timeout only clears PC and SP
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_reset_req      <= '{core_hold: 1'b1, pc_sp_clear: 1'b1, port_init: 1'b1,
                                  kind: wrc_pkg::WRC_RST_POWERON};
            o_port_data_init <= wrc_pkg::PORT_RST;
            o_port_dir_init  <= wrc_pkg::PORT_RST;
        end else begin
            o_reset_req.core_hold   <= !running || enter_rst;
            o_reset_req.pc_sp_clear <= !running || enter_rst;
            o_reset_req.port_init   <= (!running && kind_r != wrc_pkg::WRC_RST_WDT_PD) || reload;
            o_reset_req.kind        <= enter_rst ? entry_kind :
                                       running ? wrc_pkg::WRC_RST_NONE : kind_r;
            o_port_data_init        <= wrc_pkg::PORT_RST;
            o_port_dir_init         <= wrc_pkg::PORT_RST;
        end
    end

    assign o_timeout_flag   = to_r;
    assign o_powerdown_flag = pdf_r;
endmodule // wrc_watchdog_reset
`default_nettype wire
